// file: hdl/pressure_sensor_defs.vh
`ifndef PRESSURE_SENSOR_DEFS_VH
`define PRESSURE_SENSOR_DEFS_VH
// register addresses
`define ADDR_INTERRUPT_CONFIG 7'h0b
`define ADDR_THRESHOLD_LOW 7'h0c
`define ADDR_THRESHOLD_HIGH 7'h0d
`define ADDR_DEVICE_IDENTITY 7'h0f
`define ADDR_CONTROL_ONE 7'h10
`define ADDR_CONTROL_TWO 7'h11
`define ADDR_CONTROL_THREE 7'h12
`define ADDR_QUEUE_CONFIG 7'h14
`define ADDR_REF_XLOW 7'h15
`define ADDR_REF_LOW 7'h16
`define ADDR_REF_HIGH 7'h17
`define ADDR_OFFSET_LOW 7'h18
`define ADDR_OFFSET_HIGH 7'h19
`define ADDR_RESOLUTION 7'h1a
`define ADDR_INTERRUPT_SOURCE 7'h25
`define ADDR_QUEUE_STATUS 7'h26
`define ADDR_SAMPLE_STATUS 7'h27
`define ADDR_PRESS_XLOW 7'h28
`define ADDR_PRESS_LOW 7'h29
`define ADDR_PRESS_HIGH 7'h2a
`define ADDR_TEMP_LOW 7'h2b
`define ADDR_TEMP_HIGH 7'h2c
`define ADDR_FILTER_RESET 7'h33
// reset values
`define RESET_ZERO 8'h00
`define RESET_CONTROL_TWO 8'h10
// device identity, arbitrary value
`define IDENTITY_VALUE 8'h5a
// interrupt_config fields
`define BIT_AUTO_REF_ENABLE 7
`define BIT_AUTO_REF_CLEAR 6
`define BIT_ZERO_OFFSET_ENABLE 5
`define BIT_ZERO_OFFSET_CLEAR 4
`define BIT_IRQ_GEN_ENABLE 3
`define BIT_LATCH_REQUEST 2
`define BIT_LOW_IRQ_ENABLE 1
`define BIT_HIGH_IRQ_ENABLE 0
// control_two auto increment bit
`define BIT_ADDR_AUTO_INC 4
// interrupt_source fields
`define BIT_SRC_ACTIVE 2
`define BIT_SRC_LOW 1
`define BIT_SRC_HIGH 0
// calibration store
`define CAL_WORDS 8
`define CAL_ADDR_W 3
`endif

// file: hdl/calibration_store.v
`timescale 1ns/1ps
`include "pressure_sensor_defs.vh"
module calibration_store (
    input wire clock_i,
    input wire write_i,
    input wire [`CAL_ADDR_W-1:0] write_addr_i,
    input wire [7:0] write_data_i,
    input wire [`CAL_ADDR_W-1:0] read_addr_i,
    output reg [7:0] read_data_o
);
    reg [7:0] mem [0:`CAL_WORDS-1];
    always @(posedge clock_i) begin
        if (write_i) begin
            mem[write_addr_i] <= write_data_i;
        end
        read_data_o <= mem[read_addr_i];
    end
endmodule // calibration_store

// file: hdl/pressure_sensor_register_map.v
//Function
// - each 8-bit register is identified by a 7-bit address
// - factory calibration is loaded from outside through cal_load_i; host leaves it alone
// - bit 7 enables the auto reference pressure function
// - bit 6 resets the auto reference pressure function
// - bit 5 enables the autozero function
// - bit 4 resets the autozero function
// - bit 3 is the overall interrupt generation enable
// - bit 2 latches interrupt requests into interrupt_source
// - bit 1 requests interrupt when pressure falls below threshold
// - bit 0 requests interrupt on pressure high event
// - auto increment bit advances address after each byte of burst
`timescale 1ns/1ps
`include "pressure_sensor_defs.vh"
module pressure_sensor_register_map (
    input wire clock_i,
    input wire srst_i,
    input wire access_start_i,
    input wire [6:0] access_addr_i,
    input wire write_i,
    input wire [7:0] write_data_i,
    input wire read_i,
    input wire sample_valid_i,
    input wire [23:0] pressure_i,
    input wire [15:0] temperature_i,
    input wire [7:0] queue_status_i,
    input wire [7:0] filter_reset_i,
    input wire cal_load_i,
    input wire [`CAL_ADDR_W-1:0] cal_load_addr_i,
    input wire [7:0] cal_load_data_i,
    output reg [7:0] read_data_o,
    output reg read_valid_o,
    output reg interrupt_o,
    output reg auto_ref_active_o,
    output reg zero_offset_active_o,
    output reg [7:0] control_one_o,
    output reg [7:0] control_three_o,
    output reg [7:0] queue_config_o,
    output reg [7:0] resolution_config_o,
    output reg [7:0] calibration_o
);
    //---------------------------------------------------------
    // storage
    //---------------------------------------------------------
    reg [7:0] interrupt_config;
    reg [7:0] pressure_threshold_low;
    reg [7:0] pressure_threshold_high;
    reg [7:0] control_two;
    reg [7:0] reference_pressure_xlow;
    reg [7:0] reference_pressure_low;
    reg [7:0] reference_pressure_high;
    reg [7:0] pressure_offset_low;
    reg [7:0] pressure_offset_high;
    reg [7:0] interrupt_source;
    reg [7:0] sample_status;
    reg [23:0] pressure_out;
    reg [15:0] temperature_out;
    reg [23:0] zero_offset;
    reg [6:0] addr;
    reg [6:0] next_addr;
    reg [7:0] next_read;
    wire [6:0] cur_addr;
    wire [15:0] threshold;
    wire [15:0] press_top;
    wire [15:0] press_diff;
    wire low_event;
    wire high_event;
    wire [7:0] cal_data;
    //---------------------------------------------------------
    // calibration memory
    //---------------------------------------------------------
    // boot reload path
    calibration_store cal_mem (
        .clock_i(clock_i),
        .write_i(cal_load_i),
        .write_addr_i(cal_load_addr_i),
        .write_data_i(cal_load_data_i),
        .read_addr_i(cur_addr[`CAL_ADDR_W-1:0]),
        .read_data_o(cal_data)
    );
    //---------------------------------------------------------
    // address pointer
    //---------------------------------------------------------
    // seven-bit address
    assign cur_addr = access_start_i ? access_addr_i : addr;
    always @* begin
        next_addr = addr;
        if (access_start_i) begin
            next_addr = access_addr_i;
        end
        if ((write_i || read_i) && control_two[`BIT_ADDR_AUTO_INC]) begin
            next_addr = cur_addr + 7'h01;
        end else if (write_i || read_i) begin
            next_addr = cur_addr;
        end
    end
    //---------------------------------------------------------
    // threshold events
    //---------------------------------------------------------
    // threshold high byte first
    assign threshold = {pressure_threshold_high, pressure_threshold_low};
    assign press_top = pressure_i[23:8];
    assign press_diff = press_top - zero_offset[23:8];
    assign low_event = interrupt_config[`BIT_LOW_IRQ_ENABLE] && sample_valid_i &&
        interrupt_config[`BIT_IRQ_GEN_ENABLE] && (press_diff < threshold);
    assign high_event = interrupt_config[`BIT_HIGH_IRQ_ENABLE] && sample_valid_i &&
        interrupt_config[`BIT_IRQ_GEN_ENABLE] && (press_diff > threshold);
    //---------------------------------------------------------
    // read mux
    //---------------------------------------------------------
    always @* begin
        next_read = 8'h00;
        if (cur_addr == `ADDR_INTERRUPT_CONFIG) begin
            next_read = interrupt_config;
        end else if (cur_addr == `ADDR_THRESHOLD_LOW) begin
            next_read = pressure_threshold_low;
        end else if (cur_addr == `ADDR_THRESHOLD_HIGH) begin
            next_read = pressure_threshold_high;
        end else if (cur_addr == `ADDR_DEVICE_IDENTITY) begin
            next_read = `IDENTITY_VALUE;
        end else if (cur_addr == `ADDR_CONTROL_ONE) begin
            next_read = control_one_o;
        end else if (cur_addr == `ADDR_CONTROL_TWO) begin
            next_read = control_two;
        end else if (cur_addr == `ADDR_CONTROL_THREE) begin
            next_read = control_three_o;
        end else if (cur_addr == `ADDR_QUEUE_CONFIG) begin
            next_read = queue_config_o;
        end else if (cur_addr == `ADDR_REF_XLOW) begin
            next_read = reference_pressure_xlow;
        end else if (cur_addr == `ADDR_REF_LOW) begin
            next_read = reference_pressure_low;
        end else if (cur_addr == `ADDR_REF_HIGH) begin
            next_read = reference_pressure_high;
        end else if (cur_addr == `ADDR_OFFSET_LOW) begin
            next_read = pressure_offset_low;
        end else if (cur_addr == `ADDR_OFFSET_HIGH) begin
            next_read = pressure_offset_high;
        end else if (cur_addr == `ADDR_RESOLUTION) begin
            next_read = resolution_config_o;
        end else if (cur_addr == `ADDR_INTERRUPT_SOURCE) begin
            next_read = interrupt_source;
        end else if (cur_addr == `ADDR_QUEUE_STATUS) begin
            next_read = queue_status_i;
        end else if (cur_addr == `ADDR_SAMPLE_STATUS) begin
            next_read = sample_status;
        end else if (cur_addr == `ADDR_PRESS_XLOW) begin
            next_read = pressure_out[7:0];
        end else if (cur_addr == `ADDR_PRESS_LOW) begin
            next_read = pressure_out[15:8];
        end else if (cur_addr == `ADDR_PRESS_HIGH) begin
            next_read = pressure_out[23:16];
        end else if (cur_addr == `ADDR_TEMP_LOW) begin
            next_read = temperature_out[7:0];
        end else if (cur_addr == `ADDR_TEMP_HIGH) begin
            next_read = temperature_out[15:8];
        end else if (cur_addr == `ADDR_FILTER_RESET) begin
            next_read = filter_reset_i;
        end
    end
    //---------------------------------------------------------
    // registers
    //---------------------------------------------------------
    always @(posedge clock_i) begin
        if (srst_i) begin
            interrupt_config <= `RESET_ZERO;
            pressure_threshold_low <= `RESET_ZERO;
            pressure_threshold_high <= `RESET_ZERO;
            control_one_o <= `RESET_ZERO;
            control_two <= `RESET_CONTROL_TWO;
            control_three_o <= `RESET_ZERO;
            queue_config_o <= `RESET_ZERO;
            reference_pressure_xlow <= `RESET_ZERO;
            reference_pressure_low <= `RESET_ZERO;
            reference_pressure_high <= `RESET_ZERO;
            pressure_offset_low <= `RESET_ZERO;
            pressure_offset_high <= `RESET_ZERO;
            resolution_config_o <= `RESET_ZERO;
            interrupt_source <= `RESET_ZERO;
            sample_status <= `RESET_ZERO;
            pressure_out <= 24'h000000;
            temperature_out <= 16'h0000;
            zero_offset <= 24'h000000;
            addr <= 7'h00;
            read_data_o <= 8'h00;
            read_valid_o <= 1'b0;
            interrupt_o <= 1'b0;
            auto_ref_active_o <= 1'b0;
            zero_offset_active_o <= 1'b0;
            calibration_o <= 8'h00;
        end else begin
            addr <= next_addr;
            read_valid_o <= read_i;
            calibration_o <= cal_data;
            if (read_i) begin
                read_data_o <= next_read;
            end
            if (write_i) begin
                if (cur_addr == `ADDR_INTERRUPT_CONFIG) begin
                    interrupt_config <= write_data_i;
                end else if (cur_addr == `ADDR_THRESHOLD_LOW) begin
                    pressure_threshold_low <= write_data_i;
                end else if (cur_addr == `ADDR_THRESHOLD_HIGH) begin
                    pressure_threshold_high <= write_data_i;
                end else if (cur_addr == `ADDR_CONTROL_ONE) begin
                    control_one_o <= write_data_i;
                end else if (cur_addr == `ADDR_CONTROL_TWO) begin
                    control_two <= write_data_i;
                end else if (cur_addr == `ADDR_CONTROL_THREE) begin
                    control_three_o <= write_data_i;
                end else if (cur_addr == `ADDR_QUEUE_CONFIG) begin
                    queue_config_o <= write_data_i;
                end else if (cur_addr == `ADDR_REF_XLOW) begin
                    reference_pressure_xlow <= write_data_i;
                end else if (cur_addr == `ADDR_REF_LOW) begin
                    reference_pressure_low <= write_data_i;
                end else if (cur_addr == `ADDR_REF_HIGH) begin
                    reference_pressure_high <= write_data_i;
                end else if (cur_addr == `ADDR_OFFSET_LOW) begin
                    pressure_offset_low <= write_data_i;
                end else if (cur_addr == `ADDR_OFFSET_HIGH) begin
                    pressure_offset_high <= write_data_i;
                end else if (cur_addr == `ADDR_RESOLUTION) begin
                    resolution_config_o <= write_data_i;
                end
            end
            if (interrupt_config[`BIT_AUTO_REF_CLEAR]) begin
                auto_ref_active_o <= 1'b0;
                interrupt_config[`BIT_AUTO_REF_CLEAR] <= 1'b0;
            end else if (interrupt_config[`BIT_AUTO_REF_ENABLE] && !auto_ref_active_o && sample_valid_i) begin
                auto_ref_active_o <= 1'b1;
                reference_pressure_xlow <= pressure_i[7:0];
                reference_pressure_low <= pressure_i[15:8];
                reference_pressure_high <= pressure_i[23:16];
            end
            if (interrupt_config[`BIT_ZERO_OFFSET_CLEAR]) begin
                zero_offset_active_o <= 1'b0;
                zero_offset <= 24'h000000;
                interrupt_config[`BIT_ZERO_OFFSET_CLEAR] <= 1'b0;
            end else if (interrupt_config[`BIT_ZERO_OFFSET_ENABLE] && !zero_offset_active_o && sample_valid_i) begin
                zero_offset_active_o <= 1'b1;
                zero_offset <= pressure_i;
            end
            if (sample_valid_i) begin
                pressure_out <= pressure_i;
                temperature_out <= temperature_i;
                sample_status <= 8'h03;
            end else if (read_i && cur_addr == `ADDR_PRESS_HIGH) begin
                sample_status[0] <= 1'b0;
            end else if (read_i && cur_addr == `ADDR_TEMP_HIGH) begin
                sample_status[1] <= 1'b0;
            end
            if (interrupt_config[`BIT_LATCH_REQUEST]) begin
                if (low_event || high_event) begin
                    interrupt_source <= {5'b00000, 1'b1,
                        low_event | interrupt_source[`BIT_SRC_LOW],
                        high_event | interrupt_source[`BIT_SRC_HIGH]};
                end else if (read_i && cur_addr == `ADDR_INTERRUPT_SOURCE) begin
                    interrupt_source <= `RESET_ZERO;
                end
            end else if (sample_valid_i) begin
                interrupt_source <= {5'b00000, low_event | high_event, low_event, high_event};
            end
            interrupt_o <= interrupt_config[`BIT_IRQ_GEN_ENABLE] && interrupt_source[`BIT_SRC_ACTIVE];
        end
    end
endmodule // pressure_sensor_register_map

// file: verification/pressure_sensor_register_map_chk.sv
`timescale 1ns/1ps
`include "pressure_sensor_defs.vh"
module pressure_sensor_register_map_chk (
    input wire clock_i,
    input wire srst_i,
    input wire access_start_i,
    input wire [6:0] access_addr_i,
    input wire write_i,
    input wire [7:0] write_data_i,
    input wire read_i,
    input wire [7:0] read_data_o,
    input wire read_valid_o,
    input wire interrupt_o,
    input wire auto_ref_active_o,
    input wire zero_offset_active_o,
    input wire [7:0] control_one_o,
    input wire [7:0] resolution_config_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);
    // ----
    // assertions
    // ----
    read_answer_a: assert property (read_i |=> read_valid_o)
        else $error("read not answered next cycle");
    no_spurious_a: assert property (!read_i |=> !read_valid_o)
        else $error("read valid without read");
    data_holds_a: assert property (!read_i |=> $stable(read_data_o))
        else $error("read data moved without read");
    identity_read_a: assert property (read_i && access_start_i && access_addr_i == `ADDR_DEVICE_IDENTITY
        |=> read_data_o == `IDENTITY_VALUE)
        else $error("identity read wrong");
    control_write_a: assert property (write_i && access_start_i && access_addr_i == `ADDR_CONTROL_ONE
        |=> control_one_o == $past(write_data_i))
        else $error("control_one write lost");
    resolution_write_a: assert property (write_i && access_start_i && access_addr_i == `ADDR_RESOLUTION
        |=> resolution_config_o == $past(write_data_i))
        else $error("resolution write lost");
    ro_write_a: assert property (write_i && access_start_i && access_addr_i >= `ADDR_INTERRUPT_SOURCE
        |=> $stable(control_one_o) && $stable(resolution_config_o))
        else $error("read-only write changed a register");
    reset_clear_a: assert property (disable iff (1'b0) srst_i |=> !read_valid_o && !interrupt_o
        && !auto_ref_active_o && !zero_offset_active_o && control_one_o == 8'h00)
        else $error("outputs not cleared by reset");
    cover property (read_i && !access_start_i);
    cover property ($rose(interrupt_o));
    cover property (write_i && !access_start_i);
endmodule // pressure_sensor_register_map_chk
bind pressure_sensor_register_map pressure_sensor_register_map_chk chk (.clock_i(clock_i), .srst_i(srst_i),
    .access_start_i(access_start_i), .access_addr_i(access_addr_i), .write_i(write_i),
    .write_data_i(write_data_i), .read_i(read_i), .read_data_o(read_data_o), .read_valid_o(read_valid_o),
    .interrupt_o(interrupt_o), .auto_ref_active_o(auto_ref_active_o),
    .zero_offset_active_o(zero_offset_active_o), .control_one_o(control_one_o),
    .resolution_config_o(resolution_config_o));

// file: verification/host_model.sv
`timescale 1ns/1ps
module host_model (
    input wire clock_i,
    input wire [7:0] read_data_i,
    input wire read_valid_i,
    output logic access_start_o,
    output logic [6:0] access_addr_o,
    output logic write_o,
    output logic [7:0] write_data_o,
    output logic read_o
);
    initial begin
        {access_start_o, access_addr_o, write_o, write_data_o, read_o} = '0;
    end
    function automatic logic mapped(input logic [6:0] a);
        return (a >= 7'h0b && a <= 7'h0d) || (a >= 7'h0f && a <= 7'h12) || (a >= 7'h14 && a <= 7'h1a)
            || (a >= 7'h25 && a <= 7'h2c) || a == 7'h33;
    endfunction
    // ----
    // one byte transfer
    // ----
    task automatic xfer(input logic start, input logic [6:0] addr, input logic wr, input logic [7:0] wdata,
        input logic rd, output logic [7:0] rdata);
        rdata = 8'h00;
        if (!start || mapped(addr)) begin
            @(negedge clock_i);
            access_start_o = start;
            access_addr_o = addr;
            write_o = wr;
            write_data_o = wdata;
            read_o = rd;
            @(posedge clock_i);
            @(negedge clock_i);
            if (rd) rdata = read_valid_i ? read_data_i : 8'hxx;
            access_start_o = 1'b0;
            write_o = 1'b0;
            read_o = 1'b0;
            access_addr_o = ~addr;
            write_data_o = ~wdata;
        end
    endtask
endmodule // host_model

// file: verification/test_pressure_sensor_register_map.sv
`timescale 1ns/1ps
module test_pressure_sensor_register_map;
    typedef struct {logic [6:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    logic clock_i, srst_i, sample_valid_i, cal_load_i;
    logic [23:0] pressure_i;
    logic [2:0] cal_load_addr_i;
    logic [7:0] cal_load_data_i, r;
    wire access_start_i, write_i, read_i, read_valid_o, interrupt_o, auto_ref_active_o, zero_offset_active_o;
    wire [6:0] access_addr_i;
    wire [7:0] write_data_i, read_data_o, control_one_o, control_three_o, queue_config_o;
    wire [7:0] resolution_config_o, calibration_o;
    int fail_count = 0;
    int comparisons = 0;
    row_t rows[15] = '{'{7'h0c, 8'h34, 8'h34}, '{7'h0d, 8'h12, 8'h12}, '{7'h10, 8'ha5, 8'ha5},
        '{7'h11, 8'h30, 8'h30}, '{7'h12, 8'h5a, 8'h5a}, '{7'h14, 8'hc3, 8'hc3}, '{7'h15, 8'h11, 8'h11},
        '{7'h16, 8'h22, 8'h22}, '{7'h17, 8'h33, 8'h33}, '{7'h18, 8'h44, 8'h44}, '{7'h19, 8'h55, 8'h55},
        '{7'h1a, 8'h0f, 8'h0f}, '{7'h0f, 8'hff, 8'h5a}, '{7'h26, 8'hff, 8'h3c}, '{7'h33, 8'h00, 8'hc3}};
    row_t resets[9] = '{'{7'h0b, 0, 8'h00}, '{7'h0c, 0, 8'h00}, '{7'h0d, 0, 8'h00}, '{7'h0f, 0, 8'h5a},
        '{7'h10, 0, 8'h00}, '{7'h11, 0, 8'h10}, '{7'h12, 0, 8'h00}, '{7'h14, 0, 8'h00}, '{7'h1a, 0, 8'h00}};
    pressure_sensor_register_map dut (.clock_i(clock_i), .srst_i(srst_i), .access_start_i(access_start_i),
        .access_addr_i(access_addr_i), .write_i(write_i), .write_data_i(write_data_i), .read_i(read_i),
        .sample_valid_i(sample_valid_i), .pressure_i(pressure_i), .temperature_i(16'h0000),
        .queue_status_i(8'h3c), .filter_reset_i(8'hc3), .cal_load_i(cal_load_i),
        .cal_load_addr_i(cal_load_addr_i), .cal_load_data_i(cal_load_data_i), .read_data_o(read_data_o),
        .read_valid_o(read_valid_o), .interrupt_o(interrupt_o), .auto_ref_active_o(auto_ref_active_o),
        .zero_offset_active_o(zero_offset_active_o), .control_one_o(control_one_o),
        .control_three_o(control_three_o), .queue_config_o(queue_config_o),
        .resolution_config_o(resolution_config_o), .calibration_o(calibration_o));
    host_model host (.clock_i(clock_i), .read_data_i(read_data_o), .read_valid_i(read_valid_o),
        .access_start_o(access_start_i), .access_addr_o(access_addr_i), .write_o(write_i),
        .write_data_o(write_data_i), .read_o(read_i));
    // ----
    // helpers
    // ----
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] x;
        host.xfer(1'b1, a, 1'b1, d, 1'b0, x);
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] q);
        host.xfer(1'b1, a, 1'b0, 8'h00, 1'b1, q);
    endtask
    task automatic sample(input logic [23:0] p);
        @(negedge clock_i);
        pressure_i = p;
        sample_valid_i = 1'b1;
        @(negedge clock_i);
        sample_valid_i = 1'b0;
        repeat (3) @(negedge clock_i);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    initial begin
        #20000;
        fail_count++;
        give_verdict();
    end
    // ----
    // tests
    // ----
    initial begin
        {srst_i, sample_valid_i, cal_load_i, pressure_i, cal_load_addr_i, cal_load_data_i} = '0;
        srst_i = 1'b1;
        repeat (2) @(negedge clock_i);
        srst_i = 1'b0;
        for (int k = 0; k < 8; k++) begin
            cal_load_i = 1'b1;
            cal_load_addr_i = 3'(k);
            cal_load_data_i = 8'h70 + 8'(k);
            @(negedge clock_i);
        end
        cal_load_i = 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, r);
            check("register", r, rows[i].e);
        end
        check("control_three pin", control_three_o, 8'h5a);
        check("queue_config pin", queue_config_o, 8'hc3);
        wr(7'h0b, 8'h0b);
        sample(24'h120000);
        check("irq low", {7'h00, interrupt_o}, 8'h01);
        rd(7'h25, r);
        check("source low", r, 8'h06);
        sample(24'h130000);
        rd(7'h25, r);
        check("source high", r, 8'h05);
        wr(7'h0b, 8'h03);
        sample(24'h120000);
        check("irq off", {7'h00, interrupt_o}, 8'h00);
        wr(7'h0b, 8'h0d);
        sample(24'h130000);
        sample(24'h123400);
        check("irq latched", {7'h00, interrupt_o}, 8'h01);
        rd(7'h25, r);
        check("source latched", r, 8'h05);
        repeat (3) @(negedge clock_i);
        check("irq cleared", {7'h00, interrupt_o}, 8'h00);
        rd(7'h28, r);
        check("press xlow", r, 8'h00);
        host.xfer(1'b0, 7'h00, 1'b0, 8'h00, 1'b1, r);
        check("press low", r, 8'h34);
        host.xfer(1'b0, 7'h00, 1'b0, 8'h00, 1'b1, r);
        check("press high", r, 8'h12);
        host.xfer(1'b1, 7'h15, 1'b1, 8'ha1, 1'b0, r);
        host.xfer(1'b0, 7'h00, 1'b1, 8'ha2, 1'b0, r);
        rd(7'h16, r);
        check("burst inc", r, 8'ha2);
        wr(7'h11, 8'h00);
        host.xfer(1'b1, 7'h18, 1'b1, 8'h01, 1'b0, r);
        host.xfer(1'b0, 7'h00, 1'b1, 8'h02, 1'b0, r);
        rd(7'h19, r);
        check("fixed next", r, 8'h55);
        rd(7'h18, r);
        check("fixed same", r, 8'h02);
        rd(7'h0b, r);
        repeat (2) @(negedge clock_i);
        check("calibration", calibration_o, 8'h73);
        wr(7'h11, 8'h10);
        wr(7'h0b, 8'ha0);
        sample(24'h123456);
        check("auto ref on", {7'h00, auto_ref_active_o}, 8'h01);
        check("zero on", {7'h00, zero_offset_active_o}, 8'h01);
        wr(7'h0b, 8'hf0);
        rd(7'h0b, r);
        check("clear bits", r, 8'ha0);
        check("auto ref clr", {7'h00, auto_ref_active_o}, 8'h00);
        check("zero clr", {7'h00, zero_offset_active_o}, 8'h00);
        wr(7'h0b, 8'h00);
        sample(24'h123456);
        check("auto ref off", {7'h00, auto_ref_active_o}, 8'h00);
        check("zero off", {7'h00, zero_offset_active_o}, 8'h00);
        srst_i = 1'b1;
        repeat (2) @(negedge clock_i);
        srst_i = 1'b0;
        foreach (resets[i]) begin
            rd(resets[i].a, r);
            check("reset value", r, resets[i].e);
        end
        give_verdict();
    end
endmodule // test_pressure_sensor_register_map
